// ---- rls_pkg.sv ----
// Package for the receive latched status flag bank: register map, bit layout,
// timing figures and the packed carriers that join the framer and HDLC inputs.
// Assumes one 40 MHz clock and a 32-bit APB register bus with word-aligned byte addressing.
package rls_pkg;

    // Register indices as printed; the APB byte address is four times the index.
    localparam logic [11:0] IDX_LATCHED_E1_TWO   = 12'h091;
    localparam logic [11:0] IDX_LATCHED_THREE    = 12'h092;
    localparam logic [11:0] IDX_LATCHED_FOUR     = 12'h093;
    localparam logic [11:0] IDX_LATCHED_HDLC     = 12'h094;
    localparam logic [11:0] IDX_LATCHED_SEVEN_T1 = 12'h096;
    localparam logic [11:0] IDX_LINE_CONTROL     = 12'h0a0;
    localparam logic [11:0] IDX_SIG_CHANGE_EN    = 12'h0a1;
    localparam logic [11:0] IDX_HDLC_FIFO_CTRL   = 12'h0a2;
    localparam logic [11:0] PORT_STRIDE_IDX      = 12'h200;
    localparam int          PORT_COUNT           = 4;

    // Reset values.
    localparam logic [7:0]  LATCHED_RESET        = 8'h00;
    localparam logic [7:0]  CONTROL_RESET        = 8'h00;
    localparam logic [31:0] SIG_EN_RESET         = 32'h0000_0000;
    localparam logic [5:0]  WATERMARK_RESET      = 6'h20;

    // Line control field positions.
    localparam int CTL_E1_MODE  = 0;
    localparam int CTL_ESF      = 1;
    localparam int CTL_CRC4_EN  = 2;
    localparam int CTL_CAS_EN   = 3;
    localparam int CTL_TIMER_1S = 4;
    localparam int CTL_MANUAL   = 5;

    // Status bit positions.
    localparam int B3_CLK_LOST_CLR = 7;
    localparam int B3_CLK_LOST_DET = 3;
    localparam int B4_FULL    = 7;
    localparam int B4_EMPTY   = 6;
    localparam int B4_SLIP    = 5;
    localparam int B4_SIGCHG  = 3;
    localparam int B4_ONESEC  = 2;
    localparam int B4_TIMER   = 1;
    localparam int B4_MF      = 0;
    localparam int B5_OVR     = 5;
    localparam int B5_OBT     = 4;
    localparam int B5_PE      = 3;
    localparam int B5_PS      = 2;
    localparam int B5_HWM     = 1;
    localparam int B5_NE      = 0;
    localparam int B2_ZEROS   = 2;
    localparam int B2_CRCMF   = 1;
    localparam int B2_ALIGN   = 0;
    localparam int B7_RAI_CI  = 5;

    // Timing figures and the clock period, all in picoseconds.
    localparam longint CLK_PERIOD_PS   = 25000;
    localparam longint CHAN_T1_PS      = 5181347;
    localparam longint CHAN_E1_PS      = 3906250;
    localparam longint ONE_SEC_PS      = 64'd1000000000000;
    localparam longint TIMER_T1_PS     = 64'd42000000000;
    localparam longint TIMER_E1_PS     = 64'd62500000000;
    localparam longint E1_MF_PS        = 2000000000;
    localparam longint ALIGN_PS        = 250000000;

    // A lost clock is a least time, so the cycle count rounds up.
    localparam logic [8:0] CHAN_T1_CYC = 9'((CHAN_T1_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [8:0] CHAN_E1_CYC = 9'((CHAN_E1_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

    // Carriers from the framer and the HDLC receiver.
    typedef struct packed {
        logic spareMatch;
        logic loopDownMatch;
        logic loopUpMatch;
        logic distantMfAlarm;
        logic v52Present;
    } rls_line_cond_t;

    typedef struct packed {
        logic sigAllZeros;
        logic crcMfBoundary;
        logic casMfBoundary;
        logic t1MfBoundary;
        logic estoreFull;
        logic estoreEmpty;
        logic remoteAlarm;
        logic raiCiPattern;
    } rls_line_evt_t;

    typedef struct packed {
        logic       overrun;
        logic       openingNext;
        logic       packetEnd;
        logic       packetStart;
        logic [6:0] fifoLevel;
    } rls_hdlc_evt_t;

endpackage : rls_pkg

// ---- rls_rx_latched_status.sv ----
// Receive latched status flag bank for one port, with its APB slave.
// Assumes condition levels and event pulses arrive from logic on clk, except the
// receive clock pin, which is asynchronous and is synchronised here.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps

module rls_rx_latched_status
    import rls_pkg::*;
#(
    parameter logic [1:0]  PORT_NUM     = 2'd0,
    parameter logic [31:0] ONE_SEC_CYC  = 32'(ONE_SEC_PS / CLK_PERIOD_PS),
    parameter logic [31:0] TIMER_T1_CYC = 32'(TIMER_T1_PS / CLK_PERIOD_PS),
    parameter logic [31:0] TIMER_E1_CYC = 32'(TIMER_E1_PS / CLK_PERIOD_PS),
    parameter logic [31:0] E1_MF_CYC    = 32'(E1_MF_PS / CLK_PERIOD_PS),
    parameter logic [31:0] ALIGN_CYC    = 32'(ALIGN_PS / CLK_PERIOD_PS)
) (
    input  wire logic           clk,
    input  wire logic           rst,
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic [15:0]    paddr,
    input  wire logic [31:0]    pwdata,
    output logic      [31:0]    prdata,
    output logic                pready,
    output logic                pslverr,
    input  wire logic           rxClkPin,
    input  wire rls_line_cond_t lineCond,
    input  wire rls_line_evt_t  lineEvt,
    input  wire logic [31:0]    sigChangeChan,
    input  wire rls_hdlc_evt_t  hdlcEvt,
    output logic                rxClockLost
);

    ////////////////////////////////////////////////////////////////////////////
    // Shared arithmetic.

    // Free-running counter step: wraps to zero after the last count.
    function automatic logic [31:0] stepCount(input logic [31:0] cnt, input logic [31:0] last);
        stepCount = (cnt >= last) ? 32'h0000_0000 : cnt + 32'h0000_0001;
    endfunction : stepCount

    // A latched byte keeps old bits unless cleared, and a new set always wins.
    function automatic logic [7:0] latch(input logic [7:0] cur, input logic [7:0] set, input logic clr);
        latch = (clr ? 8'h00 : cur) | set;
    endfunction : latch

    ////////////////////////////////////////////////////////////////////////////
    // APB decode. The port's bank sits at PORT_NUM times the stride.

    logic [11:0] wordIdx;
    logic [11:0] localIdx;
    logic        apbAccess;
    logic        apbRead;
    logic        apbWrite;
    logic        hitE1Two;
    logic        hitThree;
    logic        hitFour;
    logic        hitHdlc;
    logic        hitSeven;
    logic        hitCtl;
    logic        hitSigEn;
    logic        hitFifoCtl;

    // Word index of the access, relative to this port's bank.
    assign wordIdx   = paddr[13:2];
    assign localIdx  = wordIdx - 12'(PORT_NUM * PORT_STRIDE_IDX);
    assign apbAccess = psel & penable;
    assign apbRead   = apbAccess & ~pwrite;
    assign apbWrite  = apbAccess & pwrite;
    assign pready    = 1'b1;

    // Address decoding as a priority chain; unmatched addresses raise pslverr.
    always_comb begin
        hitE1Two   = 1'b0;
        hitThree   = 1'b0;
        hitFour    = 1'b0;
        hitHdlc    = 1'b0;
        hitSeven   = 1'b0;
        hitCtl     = 1'b0;
        hitSigEn   = 1'b0;
        hitFifoCtl = 1'b0;
        if (paddr[1:0] != 2'h0 || paddr[15:14] != 2'h0) begin
            hitCtl = 1'b0;
        end else if (localIdx == IDX_LATCHED_E1_TWO) begin
            hitE1Two = 1'b1;
        end else if (localIdx == IDX_LATCHED_THREE) begin
            hitThree = 1'b1;
        end else if (localIdx == IDX_LATCHED_FOUR) begin
            hitFour = 1'b1;
        end else if (localIdx == IDX_LATCHED_HDLC) begin
            hitHdlc = 1'b1;
        end else if (localIdx == IDX_LATCHED_SEVEN_T1) begin
            hitSeven = 1'b1;
        end else if (localIdx == IDX_LINE_CONTROL) begin
            hitCtl = 1'b1;
        end else if (localIdx == IDX_SIG_CHANGE_EN) begin
            hitSigEn = 1'b1;
        end else if (localIdx == IDX_HDLC_FIFO_CTRL) begin
            hitFifoCtl = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software-written configuration.

    logic [7:0]  control_q;
    logic [31:0] sigEnable_q;
    logic [5:0]  watermark_q;
    logic        manualLatch;
    logic        e1Mode;

    // Manual latch is a write-one pulse; it is not stored.
    assign manualLatch = apbWrite & hitCtl & pwdata[CTL_MANUAL];
    assign e1Mode      = control_q[CTL_E1_MODE];

    // Configuration registers, written at the APB access edge.
    always_ff @(posedge clk) begin
        if (rst) begin
            control_q   <= CONTROL_RESET;
            sigEnable_q <= SIG_EN_RESET;
            watermark_q <= WATERMARK_RESET;
        end else if (apbWrite) begin
            if (hitCtl) begin
                control_q <= {3'h0, pwdata[4:0]};
            end
            if (hitSigEn) begin
                sigEnable_q <= pwdata;
            end
            if (hitFifoCtl) begin
                watermark_q <= pwdata[5:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive clock watchdog. The pin is asynchronous, so it passes three
    // flip-flops and a level change counts once the last two agree.

    logic       clkSync1_q;
    logic       clkSync2_q;
    logic       clkSync3_q;
    logic       clkLevel_q;
    logic [8:0] silentCnt_q;
    logic [8:0] chanCyc;
    logic       clkToggle;

    assign chanCyc   = e1Mode ? CHAN_E1_CYC : CHAN_T1_CYC;
    assign clkToggle = (clkSync2_q == clkSync3_q) && (clkSync3_q != clkLevel_q);

    // Synchroniser and filtered level.
    always_ff @(posedge clk) begin
        if (rst) begin
            clkSync1_q <= 1'b0;
            clkSync2_q <= 1'b0;
            clkSync3_q <= 1'b0;
            clkLevel_q <= 1'b0;
        end else begin
            clkSync1_q <= rxClkPin;
            clkSync2_q <= clkSync1_q;
            clkSync3_q <= clkSync2_q;
            if (clkSync2_q == clkSync3_q) begin
                clkLevel_q <= clkSync3_q;
            end
        end
    end

    // Silence counter; the condition holds once a channel time passes unchanged.
    always_ff @(posedge clk) begin
        if (rst) begin
            silentCnt_q <= 9'h000;
            rxClockLost <= 1'b0;
        end else if (clkToggle) begin
            silentCnt_q <= 9'h000;
            rxClockLost <= 1'b0;
        end else if (silentCnt_q >= chanCyc) begin
            rxClockLost <= 1'b1;
        end else begin
            silentCnt_q <= silentCnt_q + 9'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Free-running interval timers.

    logic [31:0] secCnt_q;
    logic [31:0] timerCnt_q;
    logic [31:0] mfCnt_q;
    logic [31:0] alignCnt_q;
    logic [31:0] timerLast;
    logic        secTick;
    logic        shortTick;
    logic        freeMfTick;
    logic        alignTick;

    assign timerLast  = e1Mode ? TIMER_E1_CYC - 32'h1 : TIMER_T1_CYC - 32'h1;
    assign secTick    = (secCnt_q == ONE_SEC_CYC - 32'h1);
    assign shortTick  = (timerCnt_q >= timerLast);
    assign freeMfTick = (mfCnt_q == E1_MF_CYC - 32'h1);
    assign alignTick  = (alignCnt_q == ALIGN_CYC - 32'h1);

    // The 2ms counter stands in for missing CRC-4 or CAS boundaries.
    always_ff @(posedge clk) begin
        if (rst) begin
            secCnt_q   <= 32'h0000_0000;
            timerCnt_q <= 32'h0000_0000;
            mfCnt_q    <= 32'h0000_0000;
            alignCnt_q <= 32'h0000_0000;
        end else begin
            secCnt_q   <= stepCount(secCnt_q, ONE_SEC_CYC - 32'h1);
            timerCnt_q <= stepCount(timerCnt_q, timerLast);
            mfCnt_q    <= stepCount(mfCnt_q, E1_MF_CYC - 32'h1);
            alignCnt_q <= stepCount(alignCnt_q, ALIGN_CYC - 32'h1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event sources for each latched register.

    logic [3:0] cond;
    logic [3:0] condPrev_q;
    logic [7:0] setTwo;
    logic [7:0] setThree;
    logic [7:0] setFour;
    logic [7:0] setHdlc;
    logic [7:0] setSeven;
    logic       aboveMark;
    logic       aboveMark_q;
    logic       notEmpty_q;
    logic       timerEvt;

    // Condition vector per mode: clock lost, then spare or nothing, then two codes.
    assign cond = e1Mode ? {rxClockLost, 1'b0, lineCond.v52Present, lineCond.distantMfAlarm}
                         : {rxClockLost, lineCond.spareMatch, lineCond.loopDownMatch, lineCond.loopUpMatch};

    // Previous condition levels for edge detection.
    always_ff @(posedge clk) begin
        if (rst) begin
            condPrev_q  <= 4'h0;
            aboveMark_q <= 1'b0;
            notEmpty_q  <= 1'b0;
        end else begin
            condPrev_q  <= cond;
            aboveMark_q <= aboveMark;
            notEmpty_q  <= (hdlcEvt.fifoLevel != 7'h00);
        end
    end

    assign aboveMark = (hdlcEvt.fifoLevel > {1'b0, watermark_q});
    assign setThree  = {~cond & condPrev_q, cond & ~condPrev_q};
    assign timerEvt  = manualLatch | (control_q[CTL_TIMER_1S] ? secTick : shortTick);

    // E1 second status: all-zeros, CRC-4 multiframe and align frame.
    assign setTwo = {5'h00,
                     e1Mode & lineEvt.sigAllZeros,
                     e1Mode & (control_q[CTL_CRC4_EN] ? lineEvt.crcMfBoundary : freeMfTick),
                     e1Mode & alignTick};

    // Elastic store, signaling change, timers and multiframe.
    assign setFour = {lineEvt.estoreFull, lineEvt.estoreEmpty,
                      lineEvt.estoreFull | lineEvt.estoreEmpty, 1'b0,
                      |(sigChangeChan & sigEnable_q),
                      secTick,
                      timerEvt,
                      e1Mode ? (control_q[CTL_CAS_EN] ? lineEvt.casMfBoundary : freeMfTick)
                             : lineEvt.t1MfBoundary};

    // HDLC receiver events.
    assign setHdlc = {2'h0, hdlcEvt.overrun,
                      hdlcEvt.openingNext, hdlcEvt.packetEnd, hdlcEvt.packetStart,
                      aboveMark & ~aboveMark_q,
                      (hdlcEvt.fifoLevel != 7'h00) & ~notEmpty_q};

    // RAI-CI only counts in T1 ESF framing while a remote alarm is present.
    assign setSeven = {2'h0, ~e1Mode & control_q[CTL_ESF] & lineEvt.remoteAlarm & lineEvt.raiCiPattern, 5'h00};

    ////////////////////////////////////////////////////////////////////////////
    // Latched registers: sticky until read, and a set beats the read clear.

    logic [7:0] latTwo_q;
    logic [7:0] latThree_q;
    logic [7:0] latFour_q;
    logic [7:0] latHdlc_q;
    logic [7:0] latSeven_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            latTwo_q   <= LATCHED_RESET;
            latThree_q <= LATCHED_RESET;
            latFour_q  <= LATCHED_RESET;
            latHdlc_q  <= LATCHED_RESET;
            latSeven_q <= LATCHED_RESET;
        end else begin
            latTwo_q   <= latch(latTwo_q, setTwo, apbRead & hitE1Two);
            latThree_q <= latch(latThree_q, setThree, apbRead & hitThree);
            latFour_q  <= latch(latFour_q, setFour, apbRead & hitFour);
            latHdlc_q  <= latch(latHdlc_q, setHdlc, apbRead & hitHdlc);
            latSeven_q <= latch(latSeven_q, setSeven, apbRead & hitSeven);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data mux; zero wait states, so data is combinational from flops and the FIFO level input.

    always_comb begin
        prdata  = 32'h0000_0000;
        pslverr = 1'b0;
        if (hitE1Two) begin
            prdata = {24'h0, latTwo_q};
        end else if (hitThree) begin
            prdata = {24'h0, latThree_q};
        end else if (hitFour) begin
            prdata = {24'h0, latFour_q};
        end else if (hitHdlc) begin
            prdata = {24'h0, latHdlc_q};
        end else if (hitSeven) begin
            prdata = {24'h0, latSeven_q};
        end else if (hitCtl) begin
            prdata = {23'h0, rxClockLost, control_q};
        end else if (hitSigEn) begin
            prdata = sigEnable_q;
        end else if (hitFifoCtl) begin
            prdata = {18'h0, hdlcEvt.fifoLevel, 1'b0, watermark_q};
        end else begin
            pslverr = psel & penable;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_zeros_e1_only: assert property (lineEvt.sigAllZeros && e1Mode && !hitE1Two |=> latTwo_q[B2_ZEROS])
        else $error("all-zeros event not latched");
    a_free_crc_mf: assert property (e1Mode && !control_q[CTL_CRC4_EN] && freeMfTick |=> latTwo_q[B2_CRCMF])
        else $error("free CRC-4 multiframe tick not latched");
    a_align_gap: assert property (alignTick |=> !alignTick [*3])
        else $error("align ticks too close");
    a_fall_sets_clear: assert property ($fell(cond[3]) |=> latThree_q[B3_CLK_LOST_CLR])
        else $error("falling clock-lost edge missed");
    a_clk_lost_time: assert property ($rose(rxClockLost) |-> $past(silentCnt_q) >= chanCyc)
        else $error("clock lost declared early");
    a_slip_pairs: assert property ($rose(latFour_q[B4_SLIP]) |-> latFour_q[B4_FULL] || latFour_q[B4_EMPTY])
        else $error("slip without full or empty");
    a_sigchg_gated: assert property ((sigChangeChan & sigEnable_q) == 32'h0 && !latFour_q[B4_SIGCHG]
                                     |=> !latFour_q[B4_SIGCHG])
        else $error("disabled channel set change flag");
    a_read_clear: assert property (apbRead && hitHdlc && setHdlc == 8'h00 |=> latHdlc_q == 8'h00)
        else $error("HDLC bank not cleared by read");
    a_set_beats_clear: assert property (apbRead && hitFour && setFour[B4_ONESEC]
                                        |=> latFour_q[B4_ONESEC])
        else $error("event lost during clearing read");
    a_rai_ci_gate: assert property (e1Mode && !latSeven_q[B7_RAI_CI] |=> !latSeven_q[B7_RAI_CI])
        else $error("RAI-CI set in E1 mode");
    a_hdlc_sticky: assert property (latHdlc_q[B5_OVR] && !(apbRead && hitHdlc) |=> latHdlc_q[B5_OVR])
        else $error("overrun flag dropped without read");

    c_clock_lost: cover property ($rose(rxClockLost));
    c_hdlc_read: cover property (apbRead && hitHdlc && latHdlc_q != 8'h00);
    c_set_on_read: cover property (apbRead && hitThree && setThree != 8'h00);
    c_bad_addr: cover property (pslverr);

endmodule : rls_rx_latched_status

// ---- rls_host_model.sv ----
// Host processor model: an APB master that runs one whole transfer per call.
// Assumes it shares the slave clock; it waits for pready under a bounded count.
`timescale 1ns/1ps
module rls_host_model (
    input  wire logic        clk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [15:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    logic timedOut;

    // Idle bus at time zero.
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0000;
        pwdata = 32'h0000_0000;
        timedOut = 1'b0;
    end

    // Setup, then access until pready; released address and data lines show inverted values so stale data never looks valid.
    task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        if (n == 50) timedOut = 1'b1;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~wd;
    endtask : xfer
endmodule : rls_host_model

// ---- tb.sv ----
// Self-checking bench for the receive latched status bank of port zero.
// Assumes shortened timing parameters; expectations follow from those values.
`timescale 1ns/1ps
module tb;
    import rls_pkg::*;
    localparam logic [15:0] A2 = {2'b00, IDX_LATCHED_E1_TWO, 2'b00};
    localparam logic [15:0] A3 = {2'b00, IDX_LATCHED_THREE, 2'b00};
    localparam logic [15:0] A4 = {2'b00, IDX_LATCHED_FOUR, 2'b00};
    localparam logic [15:0] A5 = {2'b00, IDX_LATCHED_HDLC, 2'b00};
    localparam logic [15:0] A7 = {2'b00, IDX_LATCHED_SEVEN_T1, 2'b00};
    localparam logic [15:0] AC = {2'b00, IDX_LINE_CONTROL, 2'b00};
    localparam logic [15:0] AS = {2'b00, IDX_SIG_CHANGE_EN, 2'b00};
    logic clk, rst, psel, penable, pwrite, pready, pslverr, rxClkPin, clkRun, lost, e;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, sigChangeChan, d;
    rls_line_cond_t lineCond;
    rls_line_evt_t  lineEvt;
    rls_hdlc_evt_t  hdlcEvt;
    int mismatches = 0;
    int cmp_count = 0;

    rls_rx_latched_status #(.ONE_SEC_CYC(32'd100), .TIMER_T1_CYC(32'd30), .TIMER_E1_CYC(32'd40),
        .E1_MF_CYC(32'd20), .ALIGN_CYC(32'd10)) DUT (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rxClkPin(rxClkPin), .lineCond(lineCond),
        .lineEvt(lineEvt), .sigChangeChan(sigChangeChan), .hdlcEvt(hdlcEvt), .rxClockLost(lost));
    rls_host_model host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // 40 MHz clock.
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Receive clock pin toggles every fourth cycle while clkRun is high, standing still otherwise.
    // A pin that flips every cycle would never hold still long enough for the filter to see it.
    logic [1:0] clkDiv = 2'h0;
    always @(posedge clk) begin
        clkDiv <= clkDiv + 2'h1;
        if (clkRun && clkDiv == 2'h3) rxClkPin <= ~rxClkPin;
    end

    //////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("counts: %0d compares, %0d mismatches", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : final_report

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        cmp_count++;
        if (got !== ex) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk

    // Register access; a hung bus counts as a mismatch and ends the run.
    task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] wd);
        host.xfer(w, a, wd, d, e);
        if (host.timedOut) begin
            mismatches++;
            final_report();
        end
    endtask : acc

    task automatic rdchk(input string nm, input logic [15:0] a, input logic [31:0] m, input logic [31:0] ex);
        acc(1'b0, a, 32'h0);
        chk(nm, ex, d & m);
    endtask : rdchk

    // One-cycle pulse on the line events, keeping the remote alarm level.
    task automatic pe(input logic [7:0] v, input logic [31:0] c);
        rls_line_evt_t z;
        z = rls_line_evt_t'(v & 8'h02);
        @(posedge clk);
        lineEvt <= rls_line_evt_t'(v);
        sigChangeChan <= c;
        @(posedge clk);
        lineEvt <= z;
        sigChangeChan <= 32'h0;
    endtask : pe

    //////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [15:0] al[5] = '{A2, A3, A4, A5, A7};
        foreach (al[i]) rdchk("reset value", al[i], 32'hffff_ffff, 32'h0);
        foreach (al[i]) begin
            acc(1'b0, al[i] + 16'h0800, 32'h0);
            chk("other bank err", 32'h1, {31'h0, e});
        end
        $display("test reset done");
    endtask : t_reset

    task automatic t_cond();
        for (int i = 0; i < 3; i++) begin
            @(posedge clk) lineCond <= rls_line_cond_t'(5'h10 >> i);
            rdchk("cond detect", A3, 32'hff, 32'h04 >> i);
            @(posedge clk) lineCond <= '0;
            rdchk("cond clear", A3, 32'hff, 32'h40 >> i);
        end
        clkRun <= 1'b0;
        repeat (260) @(posedge clk);
        chk("clock lost level", 32'h1, {31'h0, lost});
        rdchk("clock lost detect", A3, 32'hff, 32'h08);
        clkRun <= 1'b1;
        repeat (20) @(posedge clk);
        rdchk("clock lost clear", A3, 32'hff, 32'h80);
        $display("test conditions done");
    endtask : t_cond

    task automatic t_four();
        acc(1'b1, AS, 32'h1);
        pe(8'h08, 32'h2);
        rdchk("estore full", A4, 32'he8, 32'ha0);
        pe(8'h04, 32'h1);
        rdchk("estore empty sig", A4, 32'he8, 32'h68);
        repeat (101) @(posedge clk);
        rdchk("second and timer", A4, 32'hff, 32'h06);
        pe(8'h10, 32'h0);
        rdchk("t1 multiframe", A4, 32'h01, 32'h01);
        $display("test status four done");
    endtask : t_four

    task automatic t_hdlc();
        @(posedge clk) hdlcEvt.fifoLevel <= 7'h20;
        rdchk("not empty", A5, 32'hff, 32'h01);
        @(posedge clk) hdlcEvt.fifoLevel <= 7'h21;
        rdchk("high water", A5, 32'hff, 32'h02);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk) hdlcEvt <= rls_hdlc_evt_t'((11'h400 >> i) | 11'h21);
            @(posedge clk) hdlcEvt <= rls_hdlc_evt_t'(11'h21);
            repeat (5) @(posedge clk);
            rdchk("hdlc event", A5, 32'hff, 32'h20 >> i);
        end
        fork
            rdchk("end before race", A5, 32'hff, 32'h00);
            begin
                repeat (2) @(posedge clk);
                hdlcEvt <= rls_hdlc_evt_t'(11'h121);
                @(posedge clk) hdlcEvt <= rls_hdlc_evt_t'(11'h21);
            end
        join
        rdchk("set wins over read", A5, 32'hff, 32'h08);
        rdchk("read clears", A5, 32'hff, 32'h00);
        $display("test hdlc done");
    endtask : t_hdlc

    task automatic t_modes();
        pe(8'h03, 32'h0);
        rdchk("rai ci outside esf", A7, 32'hff, 32'h00);
        acc(1'b1, AC, 32'h2);
        pe(8'h03, 32'h0);
        rdchk("rai ci esf", A7, 32'hff, 32'h20);
        acc(1'b1, AC, 32'h1);
        acc(1'b0, A2, 32'h0);
        acc(1'b0, A4, 32'h0);
        repeat (25) @(posedge clk);
        rdchk("e1 align crc mf", A2, 32'h03, 32'h03);
        rdchk("e1 free mf", A4, 32'h01, 32'h01);
        pe(8'h80, 32'h0);
        rdchk("sig all zeros", A2, 32'h04, 32'h04);
        // With CRC-4 and CAS on, only the framer's boundaries may set the multiframe flags.
        acc(1'b1, AC, 32'h0d);
        acc(1'b0, A2, 32'h0);
        acc(1'b0, A4, 32'h0);
        repeat (25) @(posedge clk);
        rdchk("crc mf gated", A2, 32'h02, 32'h00);
        rdchk("cas mf gated", A4, 32'h01, 32'h00);
        pe(8'h60, 32'h0);
        rdchk("crc mf boundary", A2, 32'h02, 32'h02);
        rdchk("cas mf boundary", A4, 32'h01, 32'h01);
        @(posedge clk) lineCond <= rls_line_cond_t'(5'h03);
        rdchk("e1 cond detect", A3, 32'h33, 32'h03);
        @(posedge clk) lineCond <= '0;
        rdchk("e1 cond clear", A3, 32'h33, 32'h30);
        acc(1'b1, AC, 32'h31);
        rdchk("manual timer", A4, 32'h02, 32'h02);
        $display("test modes done");
    endtask : t_modes

    // Main sequence.
    initial begin
        rst = 1'b1;
        rxClkPin = 1'b0;
        clkRun = 1'b1;
        lineCond = '0;
        lineEvt = '0;
        sigChangeChan = 32'h0;
        hdlcEvt = '0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_cond();
        t_four();
        t_hdlc();
        t_modes();
        final_report();
    end
endmodule : tb
